// >>> hw/adctc_params.svh
// constants for the converter trigger and transfer control block
`ifndef ADCTC_PARAMS_SVH
`define ADCTC_PARAMS_SVH
`define ADCTC_OFS_CNT0       4'h0
`define ADCTC_OFS_CNT1       4'h1
`define ADCTC_OFS_CNT2       4'h2
`define ADCTC_OFS_CNTCTL     4'h3
`define ADCTC_OFS_RES_LO     4'h4
`define ADCTC_OFS_RES_HI     4'h5
`define ADCTC_OFS_CLR_IRQ    4'h8
`define ADCTC_OFS_GAIN       4'h9
`define ADCTC_OFS_CHAN       4'hA
`define ADCTC_OFS_MODE       4'hB
`define ADCTC_OFS_SWTRIG     4'hC
`define ADCTC_READY_BIT      4
`define ADCTC_MODE_OFF       3'h0
`define ADCTC_MODE_SW_POLL   3'h1
`define ADCTC_MODE_PACER_DMA 3'h2
`define ADCTC_MODE_PACER_INT 3'h6
`define ADCTC_CLK_HZ         20000000
`define ADCTC_CNT_CLK_HZ     2000000
`define ADCTC_CNT_DIV        (`ADCTC_CLK_HZ / `ADCTC_CNT_CLK_HZ)
`define ADCTC_FIFO_DEPTH     8
`endif

// >>> hw/adctc_pkg.sv
// types shared by the converter trigger and transfer control block
package adctc_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] data;
    } adctc_bus_type;

    typedef struct packed {
        logic [2:0] mode;
        logic [7:0] gain;
        logic [7:0] chan;
    } adctc_cfg_type;
endpackage : adctc_pkg

// >>> hw/adctc_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module adctc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,      // bus clock
    input  wire logic             rst,      // async reset
    input  wire logic             in_valid, // write request
    output logic                  in_ready, // room available
    input  wire logic [WIDTH-1:0] in_data,  // write word
    output logic                  out_valid,// word available
    input  wire logic             out_ready,// drain request
    output logic      [WIDTH-1:0] out_data  // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // flags from occupancy
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rp_reg];

    // storage
    always_ff @(posedge clk) begin
        if (push) mem[wp_reg] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop) rp_reg <= rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : adctc_fifo
`default_nettype wire

// >>> hw/adctc_pacer.sv
// cascaded 16-bit pacer counters clocked by a 2 MHz enable
`timescale 1ns/100ps
`default_nettype none
`include "adctc_params.svh"
module adctc_pacer import adctc_pkg::*; (
    input  wire logic        clk,     // bus clock
    input  wire logic        rst,     // async reset
    input  wire logic        tick,    // 2 MHz count enable
    input  wire logic [15:0] div1,    // counter 1 reload
    input  wire logic [15:0] div2,    // counter 2 reload
    output logic             fire     // one pulse per terminal count
);
    logic [15:0] c1_reg;
    logic [15:0] c2_reg;
    logic [15:0] d1_reg;
    logic [15:0] d2_reg;
    wire         c1_tc  = tick && (c1_reg <= 16'h0001);
    wire         c2_tc  = c1_tc && (c2_reg <= 16'h0001);
    // a new reload value restarts the count instead of waiting a full wrap
    wire         reload = (div1 != d1_reg) || (div2 != d2_reg);

    // counter 1 feeds counter 2, forming a 32-bit divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c1_reg <= 16'hFFFF;
            c2_reg <= 16'hFFFF;
            d1_reg <= 16'hFFFF;
            d2_reg <= 16'hFFFF;
            fire   <= 1'b0;
        end else if (reload) begin
            c1_reg <= div1;
            c2_reg <= div2;
            d1_reg <= div1;
            d2_reg <= div2;
            fire   <= 1'b0;
        end else begin
            if (tick) c1_reg <= c1_tc ? div1 : c1_reg - 16'h0001;
            if (c1_tc) c2_reg <= c2_tc ? div2 : c2_reg - 16'h0001;
            fire <= c2_tc;
        end
    end
endmodule : adctc_pacer
`default_nettype wire

// >>> hw/adctc_top.sv
// converter trigger and transfer control, top level on the byte port
`timescale 1ns/100ps
`default_nettype none
`include "adctc_params.svh"
module adctc_top import adctc_pkg::*; (
    input  wire logic        clk,                 // 20 MHz bus clock
    input  wire logic        rst,                 // async reset
    input  wire logic [3:0]  io_addr,             // port offset
    input  wire logic        io_wr,               // write strobe
    input  wire logic        io_rd,               // read strobe
    input  wire logic [7:0]  io_wdata,            // write data
    output logic      [7:0]  io_rdata,            // read data
    input  wire logic        dma_ack,             // dma acknowledge
    input  wire logic        trigger_source_jumper, // 1 = external
    input  wire logic        external_conversion_trigger, // ext trigger
    input  wire logic        conv_done,           // converter end
    input  wire logic [11:0] conv_data,           // converter result
    output logic             conv_start,          // start pulse
    output logic      [7:0]  gain_out,            // amplifier gain code
    output logic      [3:0]  chan_out,            // mux channel
    output logic             irq_out,             // interrupt request
    output logic             dma_req,             // dma request
    output logic      [15:0] cnt0_out,            // counter 0 value
    output logic             cnt0_tc              // counter 0 terminal
);
    adctc_bus_type bus;
    adctc_cfg_type cfg_reg;
    logic [15:0]   div1_reg;
    logic [15:0]   div2_reg;
    logic [15:0]   cnt0_reg;
    logic [15:0]   cnt0_load_reg;
    logic [1:0]    lbyte_reg;
    logic [3:0]    div_reg;
    logic          busy_reg;
    logic          irq_flag_reg;
    logic          ext_d_reg;
    logic [1:0]    dma_phase_reg;
    logic [11:0]   result_reg;
    logic          pacer_fire;
    logic          f_valid;
    logic          f_ready;
    logic [11:0]   f_data;

    function automatic logic wr_at(input adctc_bus_type b,
                                   input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction : wr_at

    // port strobes gathered into one carrier
    assign bus = '{wr: io_wr, rd: io_rd, addr: io_addr, data: io_wdata};

    // mode decode per trigger source selection
    wire ext_sel  = trigger_source_jumper;
    wire m_sw     = !ext_sel && cfg_reg.mode == `ADCTC_MODE_SW_POLL;
    wire m_pdma   = cfg_reg.mode == `ADCTC_MODE_PACER_DMA;
    wire m_pint   = cfg_reg.mode == `ADCTC_MODE_PACER_INT;
    wire use_dma  = m_pdma;
    wire use_int  = m_pint;
    wire ext_rise = external_conversion_trigger && !ext_d_reg;
    wire trig_sw  = wr_at(bus, `ADCTC_OFS_SWTRIG) && m_sw;
    wire trig_pac = !ext_sel && (m_pdma || m_pint) && pacer_fire;
    wire trig_ext = ext_sel && (m_pdma || m_pint) && ext_rise;
    wire trig     = (trig_sw || trig_pac || trig_ext) && !busy_reg;
    wire done     = busy_reg && conv_done;
    wire tick     = (div_reg == 4'(`ADCTC_CNT_DIV - 1));
    // counter 0 word as it stands once the byte being written lands
    wire [15:0] cnt0_new = lbyte_reg[0] ? {bus.data, cnt0_load_reg[7:0]}
                                        : {cnt0_load_reg[15:8], bus.data};

    // trigger stage: pacer from two cascaded counters
    adctc_pacer u_pacer (
        .clk  (clk),
        .rst  (rst),
        .tick (tick),
        .div1 (div1_reg),
        .div2 (div2_reg),
        .fire (pacer_fire)
    );

    // transfer stage: results queue for the dma byte pair
    adctc_fifo #(.WIDTH(12), .DEPTH(`ADCTC_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (done && use_dma),
        .in_ready  (),
        .in_data   (conv_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );
    // drained after the second byte of a pair is acknowledged
    assign f_ready = dma_ack && dma_phase_reg == 2'h2;

    // write-only configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= '0;
        end else begin
            if (wr_at(bus, `ADCTC_OFS_GAIN)) cfg_reg.gain <= bus.data;
            if (wr_at(bus, `ADCTC_OFS_CHAN)) cfg_reg.chan <= bus.data;
            if (wr_at(bus, `ADCTC_OFS_MODE))
                cfg_reg.mode <= bus.data[2:0];
        end
    end

    // counter reload bytes, low then high; counters 1 and 2 share one byte flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div1_reg      <= 16'hFFFF;
            div2_reg      <= 16'hFFFF;
            cnt0_load_reg <= 16'hFFFF;
            lbyte_reg     <= '0;
        end else begin
            if (wr_at(bus, `ADCTC_OFS_CNTCTL)) lbyte_reg <= '0;
            if (wr_at(bus, `ADCTC_OFS_CNT0)) begin
                lbyte_reg[0]  <= ~lbyte_reg[0];
                cnt0_load_reg <= cnt0_new;
            end
            if (wr_at(bus, `ADCTC_OFS_CNT1)) begin
                lbyte_reg[1] <= ~lbyte_reg[1];
                if (lbyte_reg[1]) div1_reg[15:8] <= bus.data;
                else div1_reg[7:0] <= bus.data;
            end
            if (wr_at(bus, `ADCTC_OFS_CNT2)) begin
                lbyte_reg[1] <= ~lbyte_reg[1];
                if (lbyte_reg[1]) div2_reg[15:8] <= bus.data;
                else div2_reg[7:0] <= bus.data;
            end
        end
    end

    // 2 MHz count enable and counter 0 down counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg  <= '0;
            cnt0_reg <= 16'hFFFF;
            cnt0_tc  <= 1'b0;
        end else begin
            div_reg <= tick ? 4'h0 : div_reg + 4'h1;
            if (wr_at(bus, `ADCTC_OFS_CNT0)) cnt0_reg <= cnt0_new;
            else if (tick) cnt0_reg <= cnt0_reg - 16'h0001;
            cnt0_tc <= tick && cnt0_reg == 16'h0001;
        end
    end
    assign cnt0_out = cnt0_reg;

    // conversion status and result capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg     <= 1'b0;
            result_reg   <= '0;
            irq_flag_reg <= 1'b0;
            ext_d_reg    <= 1'b0;
            conv_start   <= 1'b0;
        end else begin
            ext_d_reg  <= external_conversion_trigger;
            conv_start <= trig;
            if (trig) busy_reg <= 1'b1;
            else if (done) busy_reg <= 1'b0;
            if (done) result_reg <= conv_data;
            if (done && use_int) irq_flag_reg <= 1'b1;
            else if (wr_at(bus, `ADCTC_OFS_CLR_IRQ))
                irq_flag_reg <= 1'b0;
        end
    end

    // dma: two requests per result, low byte then high byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dma_phase_reg <= '0;
        end else if (dma_phase_reg == 2'h0) begin
            if (f_valid && use_dma) dma_phase_reg <= 2'h1;
        end else if (dma_ack) begin
            dma_phase_reg <= (dma_phase_reg == 2'h1) ? 2'h2 : 2'h0;
        end
    end

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_rdata <= '0;
            gain_out <= '0;
            chan_out <= '0;
            irq_out  <= 1'b0;
            dma_req  <= 1'b0;
        end else begin
            gain_out <= cfg_reg.gain;
            chan_out <= cfg_reg.chan[3:0];
            irq_out  <= irq_flag_reg;
            dma_req  <= dma_phase_reg != 2'h0 && !dma_ack;
            unique case (1'b1)
                dma_ack && dma_phase_reg == 2'h1:
                    io_rdata <= f_data[7:0];
                dma_ack && dma_phase_reg == 2'h2:
                    io_rdata <= {4'h0, f_data[11:8]};
                bus.rd && bus.addr == `ADCTC_OFS_RES_LO:
                    io_rdata <= result_reg[7:0];
                bus.rd && bus.addr == `ADCTC_OFS_RES_HI:
                    io_rdata <= {3'h0, busy_reg, result_reg[11:8]};
                bus.rd && bus.addr == `ADCTC_OFS_CNT0:
                    io_rdata <= cnt0_reg[7:0];
                default:
                    io_rdata <= 8'h00;
            endcase
        end
    end

    // decoded strobes watched by the checks below
    wire wr_gain = wr_at(bus, `ADCTC_OFS_GAIN);
    wire wr_chan = wr_at(bus, `ADCTC_OFS_CHAN);
    wire wr_mode = wr_at(bus, `ADCTC_OFS_MODE);
    wire wr_clr  = wr_at(bus, `ADCTC_OFS_CLR_IRQ);
    wire wr_cnt0 = wr_at(bus, `ADCTC_OFS_CNT0);
    wire rd_high = bus.rd && bus.addr == `ADCTC_OFS_RES_HI && !dma_ack;

    // steps: low byte handed over, fresh word queued, flag cleared
    sequence pair_s;
        dma_phase_reg == 2'h1 && dma_ack ##1 dma_phase_reg == 2'h2;
    endsequence
    sequence queue_s;
        done && use_dma && !f_valid ##1 use_dma;
    endsequence
    sequence clear_s;
        wr_clr && !(done && use_int);
    endsequence

    // a trigger marks the result not ready on the next cycle
    ready_sets_a: assert property (@(posedge clk) disable iff (rst)
        trig |=> busy_reg)
        else $error("trigger did not set busy");
    // end of conversion marks it ready again
    ready_clears_a: assert property (@(posedge clk) disable iff (rst)
        done && !trig |=> !busy_reg)
        else $error("busy not cleared");
    // a software trigger starts the converter
    swtrig_start_a: assert property (@(posedge clk) disable iff (rst)
        trig_sw && !busy_reg |=> conv_start)
        else $error("no sw start");
    // the start is a single pulse per trigger
    start_pulse_a: assert property (@(posedge clk) disable iff (rst)
        conv_start |=> !conv_start)
        else $error("start pulse too long");

    // interrupt flag set, held and cleared
    irq_set_a: assert property (@(posedge clk) disable iff (rst)
        done && use_int |=> ##1 irq_out)
        else $error("irq missing");
    // a clear write drops the request two cycles on
    irq_clear_a: assert property (@(posedge clk) disable iff (rst)
        clear_s |=> !irq_flag_reg ##1 !irq_out)
        else $error("irq not cleared");
    // the flag stays until the host clears it
    irq_hold_a: assert property (@(posedge clk) disable iff (rst)
        irq_flag_reg && !wr_clr |=> irq_flag_reg)
        else $error("irq flag lost");
    // polled mode raises no interrupt
    mode_quiet_a: assert property (@(posedge clk) disable iff (rst)
        m_sw |=> !irq_flag_reg || $past(irq_flag_reg))
        else $error("irq in polled mode");
    // polled mode starts no dma pair
    dma_quiet_a: assert property (@(posedge clk) disable iff (rst)
        m_sw && dma_phase_reg == 2'h0 |=> dma_phase_reg == 2'h0)
        else $error("dma in polled mode");

    // mode and source decide which triggers count
    off_quiet_a: assert property (@(posedge clk) disable iff (rst)
        cfg_reg.mode == `ADCTC_MODE_OFF |=> !conv_start)
        else $error("start while off");
    // external source starts only on an edge
    ext_only_a: assert property (@(posedge clk) disable iff (rst)
        ext_sel && !trig_ext |=> !conv_start)
        else $error("start without ext edge");
    // external trigger is edge sensitive
    ext_edge_a: assert property (@(posedge clk) disable iff (rst)
        trig_ext |-> $rose(external_conversion_trigger))
        else $error("ext trigger not an edge");
    // pacer triggers only in the pacer modes
    pacer_only_a: assert property (@(posedge clk) disable iff (rst)
        trig_pac |-> (m_pdma || m_pint))
        else $error("pacer off mode");
    // each pacer terminal count in a pacer mode while idle on the internal source starts a conversion
    pacer_start_a: assert property (@(posedge clk) disable iff (rst)
        pacer_fire && !busy_reg && !ext_sel && (m_pdma || m_pint)
        |=> conv_start)
        else $error("pacer start missing");

    // dma: the high byte request follows the low byte
    dma_pair_a: assert property (@(posedge clk) disable iff (rst)
        pair_s ##0 !dma_ack |=> dma_req)
        else $error("dma pair cut");
    // a queued word opens a pair
    dma_queue_a: assert property (@(posedge clk) disable iff (rst)
        queue_s |=> dma_phase_reg == 2'h1)
        else $error("dma pair not opened");
    // an open byte is requested until acknowledged
    dma_ask_a: assert property (@(posedge clk) disable iff (rst)
        dma_phase_reg != 2'h0 && !dma_ack |=> dma_req)
        else $error("dma request missing");

    // register copies and result capture
    gain_copy_a: assert property (@(posedge clk) disable iff (rst)
        wr_gain |=> ##1 gain_out == $past(bus.data, 2))
        else $error("gain code not copied");
    // channel code reaches the mux, low four bits
    chan_copy_a: assert property (@(posedge clk) disable iff (rst)
        wr_chan |=> ##1 chan_out == $past(bus.data[3:0], 2))
        else $error("channel code not copied");
    // only the low three mode bits are kept
    mode_take_a: assert property (@(posedge clk) disable iff (rst)
        wr_mode |=> cfg_reg.mode == $past(bus.data[2:0]))
        else $error("mode field wrong");
    // the result word is taken at end of conversion
    result_a: assert property (@(posedge clk) disable iff (rst)
        done |=> result_reg == $past(conv_data))
        else $error("result not captured");
    // high byte read shows the ready status
    ready_rd_a: assert property (@(posedge clk) disable iff (rst)
        rd_high |=> io_rdata[4] == $past(busy_reg))
        else $error("ready bit wrong");
    // counter 0 reports its terminal count
    cnt0_end_a: assert property (@(posedge clk) disable iff (rst)
        tick && cnt0_reg == 16'h0001 && !wr_cnt0 |=> cnt0_tc
        && cnt0_out == 16'h0000)
        else $error("counter0 end missing");
endmodule : adctc_top
`default_nettype wire

// >>> verification/adctc_conv_model.sv
// converter stand-in: answers each start pulse taken while idle with a done pulse and a word
`timescale 1ns/100ps
`default_nettype none
module adctc_conv_model #(
    parameter int LAT = 20              // conversion time in clocks
) (
    input  wire logic        clk,       // bus clock
    input  wire logic        rst,       // async reset
    input  wire logic        conv_start,// start pulse
    output logic             conv_done, // end pulse
    output logic      [11:0] conv_data, // result word
    output logic      [11:0] last_word, // word of the latest conversion
    output int               n_done     // conversions finished
);
    int          cnt;
    logic [11:0] word;
    // the word only holds in the done cycle, so a late sample sees garbage
    assign conv_data = conv_done ? word : ~word;
    // starts while converting are ignored, as a real converter would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            conv_done <= 1'b0;
            word <= 12'h5A3;
            last_word <= 12'h000;
            n_done <= 0;
        end else begin
            conv_done <= 1'b0;
            if (cnt == 0 && conv_start) cnt <= LAT;
            else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1) begin
                cnt <= 0;
                conv_done <= 1'b1;
                last_word <= word;
                n_done <= n_done + 1;
            end
            if (conv_done) word <= word + 12'h10F;
        end
    end
endmodule : adctc_conv_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the trigger and transfer control top
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk, rst, io_wr, io_rd, dma_ack, jmp, ext;
    logic        conv_start, conv_done, irq_out, dma_req, cnt0_tc;
    logic [3:0]  io_addr, chan_out;
    logic [7:0]  io_wdata, io_rdata, gain_out, d;
    logic [11:0] conv_data, w;
    logic [15:0] cnt0_out;
    int          n_done, bad_count, n_compared, starts, irqs, dmas;
    int          s, i, p1, p2;
    adctc_top i_dut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .dma_ack(dma_ack), .trigger_source_jumper(jmp),
        .external_conversion_trigger(ext), .conv_done(conv_done),
        .conv_data(conv_data), .conv_start(conv_start), .gain_out(gain_out),
        .chan_out(chan_out), .irq_out(irq_out), .dma_req(dma_req),
        .cnt0_out(cnt0_out), .cnt0_tc(cnt0_tc));
    adctc_conv_model #(.LAT(20)) i_conv (.clk(clk), .rst(rst),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
        .last_word(w), .n_done(n_done));
    // clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // counts cycles in which start, interrupt and dma request are high
    always @(posedge clk) begin
        if (conv_start === 1'b1) starts++;
        if (irq_out === 1'b1) irqs++;
        if (dma_req === 1'b1) dmas++;
    end
    // wait n cycles, landing just after the edge
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk);
            #5;
        end
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        cyc(1);
        io_addr = a;
        io_wdata = v;
        io_wr = 1'b1;
        cyc(1);
        io_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        cyc(1);
        io_addr = a;
        io_rd = 1'b1;
        cyc(1);
        io_rd = 1'b0;
        v = io_rdata;
    endtask : rd
    // one dma acknowledge, data taken the cycle after
    task automatic dack(output logic [7:0] v);
        cyc(1);
        dma_ack = 1'b1;
        cyc(1);
        dma_ack = 1'b0;
        v = io_rdata;
    endtask : dack
    task automatic chk(input logic [15:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    // cycles until the next start pulse, bounded
    task automatic next_start(output int c);
        s = starts;
        for (c = 0; c < 5000 && starts == s; c++) cyc(1);
    endtask : next_start
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // watchdog well past the expected run
    initial begin
        #(50 * 40000);
        bad_count++;
        give_verdict();
    end
    initial begin
        {rst, io_wr, io_rd, dma_ack, jmp, ext} = 6'b100000;
        io_addr = 4'h0;
        io_wdata = 8'h00;
        repeat (5) @(posedge clk);
        #5 rst = 1'b0;
        chk(cnt0_out, 16'hFFFF, "counter0 reset");
        chk({irq_out, dma_req}, 16'h0000, "irq dma reset");
        rd(4'h5, d);
        chk(d[4], 1'b0, "ready after reset");
        rd(4'hF, d);
        chk(d, 8'h00, "unmapped read");
        $display("test reset done");
        wr(4'h9, 8'hA5);
        wr(4'hA, 8'h3C);
        cyc(1);
        chk(gain_out, 8'hA5, "gain code");
        chk(chan_out, 4'hC, "channel code");
        // settling delay timed by counter 0 on the 2 MHz tick
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h05);
        wr(4'h0, 8'h00);
        for (i = 0; i < 200 && cnt0_tc !== 1'b1; i++) cyc(1);
        chk(i >= 41 && i <= 50, 1'b1, "counter0 delay length");
        chk(cnt0_out, 16'h0000, "counter0 at terminal count");
        $display("test select done");
        {irqs, dmas} = 0;
        wr(4'hB, 8'h01);
        s = starts;
        wr(4'hC, 8'h00);
        wr(4'hC, 8'hFF);
        rd(4'h5, d);
        chk(d[4], 1'b1, "not ready while converting");
        chk(starts - s, 1, "one start per trigger");
        for (i = 0; i < 100 && d[4] !== 1'b0; i++) rd(4'h5, d);
        chk(d, {4'h0, w[11:8]}, "high byte and ready");
        rd(4'h4, d);
        chk(d, w[7:0], "low byte");
        chk(irqs + dmas, 0, "no irq or dma in polling");
        $display("test software done");
        wr(4'hB, 8'h00);
        s = starts;
        wr(4'hC, 8'h00);
        cyc(40);
        chk(starts - s, 0, "mode off ignores trigger");
        $display("test off done");
        wr(4'h3, 8'h00);
        wr(4'h1, 8'h04);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h04);
        wr(4'h2, 8'h00);
        {irqs, dmas} = 0;
        wr(4'hB, 8'hF6);
        for (i = 0; i < 5000 && irq_out !== 1'b1; i++) cyc(1);
        chk(irq_out, 1'b1, "irq after pacer conversion");
        rd(4'h5, d);
        chk(d, {4'h0, w[11:8]}, "pacer result polled");
        wr(4'h8, 8'h5A);
        cyc(1);
        chk(irq_out, 1'b0, "irq cleared");
        next_start(p1);
        next_start(p1);
        next_start(p2);
        chk(p1 == p2 && p1 < 5000, 1'b1, "pacer period steady");
        for (i = 0; i < 100 && irq_out !== 1'b1; i++) cyc(1);
        chk(irq_out, 1'b1, "irq rearmed");
        chk(dmas, 0, "no dma in irq mode");
        wr(4'hB, 8'h00);
        wr(4'h8, 8'h00);
        cyc(40);
        $display("test pacer irq done");
        irqs = 0;
        wr(4'hB, 8'h02);
        for (i = 0; i < 5000 && dma_req !== 1'b1; i++) cyc(1);
        chk(dma_req, 1'b1, "dma request");
        dack(d);
        chk(d, w[7:0], "dma low byte");
        for (i = 0; i < 100 && dma_req !== 1'b1; i++) cyc(1);
        dack(d);
        chk(d, {4'h0, w[11:8]}, "dma high byte");
        chk(irqs, 0, "no irq in dma mode");
        wr(4'hB, 8'h00);
        cyc(40);
        $display("test pacer dma done");
        jmp = 1'b1;
        wr(4'hB, 8'h01);
        s = starts;
        wr(4'hC, 8'h00);
        cyc(30);
        chk(starts - s, 0, "external 001 enables nothing");
        wr(4'hB, 8'h06);
        cyc(400);
        chk(starts - s, 0, "pacer idle with external source");
        ext = 1'b1;
        cyc(3);
        ext = 1'b0;
        cyc(3);
        chk(starts - s, 1, "edge starts one conversion");
        for (i = 0; i < 100 && irq_out !== 1'b1; i++) cyc(1);
        chk(irq_out, 1'b1, "external irq");
        wr(4'h8, 8'h00);
        $display("test external done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
